// [tne_pkg.sv]
package tne_pkg;

    localparam int CLK_HZ     = 40_000_000;
    localparam int MS_PER_S   = 1000;
    localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
    localparam int FRAME_BITS = 24;
    localparam int TIME_W     = 16;

    ////////////////////////////////////////////////////////////////////////
    // host frame field positions, byte 0 in [23:16]
    localparam int CMD_HI     = 23;
    localparam int CMD_LO     = 21;
    localparam int COMPAT_BIT = 20;
    localparam int SCRL_BIT   = 19;
    localparam int GRP_HI     = 18;
    localparam int GRP_LO     = 16;
    localparam int ONDUR_HI   = 14;
    localparam int ONDUR_LO   = 13;
    localparam int INTEG_BIT  = 12;
    localparam int BAW_BIT    = 11;
    localparam int SLP_HI     = 10;
    localparam int SLP_LO     = 8;
    localparam int RES_HI     = 7;
    localparam int RES_LO     = 5;
    localparam int SRECAL_BIT = 4;
    localparam int KRECAL_BIT = 3;
    localparam int KEY_HI     = 2;
    localparam int KEY_LO     = 0;

    localparam logic [2:0] CMD_NORMAL = 3'h0;

    localparam logic [2:0] SLP_FREE  = 3'h0;
    localparam logic [2:0] SLP_480   = 3'h4;
    localparam logic [2:0] SLP_SYNC  = 3'h5;
    localparam logic [2:0] SLP_SLEEP = 3'h6;
    localparam logic [2:0] SLP_RSVD  = 3'h7;

    localparam logic [TIME_W-1:0] SLEEP1_MS = 16'h003c;
    localparam logic [TIME_W-1:0] SLEEP2_MS = 16'h0078;
    localparam logic [TIME_W-1:0] SLEEP3_MS = 16'h00f0;
    localparam logic [TIME_W-1:0] SLEEP4_MS = 16'h01e0;

    localparam int ONDUR0_S = 10;
    localparam int ONDUR1_S = 20;
    localparam int ONDUR2_S = 60;
    localparam logic [TIME_W-1:0] ONDUR0_MS = TIME_W'(ONDUR0_S * MS_PER_S);
    localparam logic [TIME_W-1:0] ONDUR1_MS = TIME_W'(ONDUR1_S * MS_PER_S);
    localparam logic [TIME_W-1:0] ONDUR2_MS = TIME_W'(ONDUR2_S * MS_PER_S);
    localparam logic [1:0]        ONDUR_OFF = 2'h3;

    localparam logic [2:0] INTEG_SHORT = 3'h2;
    localparam logic [2:0] INTEG_LONG  = 3'h6;
    localparam logic [2:0] RES_RSVD = 3'h0;

    typedef struct packed {
        logic [2:0] key_grouping_suppression;
        logic       scroller_type_select;
        logic       proximity_compat_bit;
        logic [2:0] sleep_interval_select;
        logic       burst_after_wake;
        logic       detect_integrator;
        logic [1:0] max_on_duration;
        logic [2:0] resolution;
    } tne_cfg_s;

    localparam tne_cfg_s CFG_RESET = '{3'h0, 1'b0, 1'b0, 3'h0, 1'b1, 1'b1, 2'h0, 3'h6};

    typedef struct packed {
        logic       scroller_calibrating;
        logic       key_calibrating;
        logic       scroller_error;
        logic       key_error;
        logic       threshold_loaded;
        logic       scroller_touched;
        logic [6:0] keys_touched;
        logic [7:0] position;
    } tne_status_s;

endpackage

// [tne_ms_timer.sv]
`timescale 1ns/1ps
module tne_ms_timer
    import tne_pkg::*;
#(
    parameter int W = TIME_W
) (
    input  logic         clk,
    input  logic         rst_n,
    input  logic         ms_tick,
    input  logic         run,
    input  logic [W-1:0] limit,
    output logic         done_q
);
    logic [W-1:0] cnt_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q  <= '0;
            done_q <= 1'b0;
        end else if (!run) begin
            cnt_q  <= '0;
            done_q <= 1'b0;
        end else if (ms_tick) begin
            if (cnt_q + 1'b1 >= limit) begin
                cnt_q  <= '0;
                done_q <= 1'b1;
            end else begin
                cnt_q  <= cnt_q + 1'b1;
                done_q <= 1'b0;
            end
        end else begin
            done_q <= 1'b0;
        end
    end

    timer_done_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        done_q |-> $past(ms_tick) && $past(run))
    else $error("timer expired without a running millisecond tick");

endmodule

// [tne_spi_slave.sv]
`timescale 1ns/1ps
module tne_spi_slave
    import tne_pkg::*;
(
    input  logic                  clk,
    input  logic                  rst_n,
    input  logic                  sclk_s,
    input  logic                  ss_n_s,
    input  logic                  mosi_s,
    input  logic [FRAME_BITS-1:0] tx_frame,
    output logic                  miso_q,
    output logic                  miso_oe_q,
    output logic                  frame_ok_q,
    output logic [FRAME_BITS-1:0] rx_q
);
    logic                  sclk_d_q;
    logic                  ss_d_q;
    logic [4:0]            cnt_q;
    logic                  full_q;
    logic [FRAME_BITS-1:0] tx_q;
    logic                  rise;
    logic                  fall;
    logic                  ss_fall;
    logic                  ss_rise;

    assign rise    = sclk_s & ~sclk_d_q & ~ss_n_s;
    assign fall    = ~sclk_s & sclk_d_q & ~ss_n_s;
    assign ss_fall = ss_d_q & ~ss_n_s;
    assign ss_rise = ~ss_d_q & ss_n_s;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_d_q <= 1'b0;
            ss_d_q   <= 1'b1;
        end else begin
            sclk_d_q <= sclk_s;
            ss_d_q   <= ss_n_s;
        end
    end

    // receive, mode 0, msb first; bits past the third byte are dropped
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q  <= '0;
            full_q <= 1'b0;
            rx_q   <= '0;
        end else if (ss_fall) begin
            cnt_q  <= '0;
            full_q <= 1'b0;
        end else if (rise && !full_q) begin
            rx_q  <= {rx_q[FRAME_BITS-2:0], mosi_s};
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == 5'(FRAME_BITS - 1)) begin
                full_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_q      <= '0;
            miso_q    <= 1'b0;
            miso_oe_q <= 1'b0;
        end else begin
            miso_oe_q <= ~ss_n_s;
            if (ss_fall) begin
                tx_q   <= tx_frame;
                miso_q <= tx_frame[FRAME_BITS-1];
            end else if (fall) begin
                tx_q   <= {tx_q[FRAME_BITS-2:0], 1'b0};
                miso_q <= tx_q[FRAME_BITS-2];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_ok_q <= 1'b0;
        end else begin
            frame_ok_q <= ss_rise & full_q;
        end
    end

    partial_drop_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        ss_rise && !full_q |=> !frame_ok_q)
    else $error("short exchange accepted");

endmodule

// [tne_decoder.sv]
`timescale 1ns/1ps
module tne_decoder
    import tne_pkg::*;
#(
    parameter int CYC_PER_MS_P = CYC_PER_MS
) (
    input  logic                  clk,
    input  logic                  rst_n,
    input  logic                  spi_sclk,
    input  logic                  spi_ss_n,
    input  logic                  spi_mosi,
    output logic                  spi_miso,
    output logic                  spi_miso_oe,
    input  tne_status_s           status,
    input  logic                  acq_busy,
    input  logic [FRAME_BITS-1:0] alt_report,
    output tne_cfg_s              cfg_q,
    output logic [2:0]            res_active_q,
    output logic [2:0]            confirm_count_q,
    output logic                  burst_req_q,
    output logic                  key_recal_q,
    output logic [2:0]            key_recal_target_q,
    output logic                  scroller_recal_q,
    output logic                  ondur_recal_all_q,
    output logic                  cmd_valid_q,
    output logic [FRAME_BITS-1:0] cmd_word_q,
    output logic [2:0]            pending_cmd_q
);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [2:0] pin_s1_q;
    logic [2:0] pin_s2_q;
    logic       ss_d_q;
    logic       ss_rise;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_q <= 3'h1;
            pin_s2_q <= 3'h1;
        end else begin
            pin_s1_q <= {spi_mosi, spi_sclk, spi_ss_n};
            pin_s2_q <= pin_s1_q;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ss_d_q <= 1'b1;
        end else begin
            ss_d_q <= pin_s2_q[0];
        end
    end

    // any rising edge of select, bare pulse or full exchange
    assign ss_rise = pin_s2_q[0] & ~ss_d_q;

    ////////////////////////////////////////////////////////////////////////
    // shift engine and report assembly
    logic                  frame_ok;
    logic [FRAME_BITS-1:0] rx_word;
    logic [FRAME_BITS-1:0] tx_frame;
    logic [FRAME_BITS-1:0] normal_report;
    logic [2:0]            rx_cmd;
    logic                  low_power;

    assign rx_cmd    = rx_word[CMD_HI:CMD_LO];
    assign low_power = cfg_q.sleep_interval_select != SLP_FREE;

    // proximity flag reads zero: the device has no proximity mode
    assign normal_report = {status.scroller_calibrating,
                            status.key_calibrating,
                            status.scroller_error,
                            status.key_error,
                            low_power,
                            1'b0,
                            1'b0,
                            status.threshold_loaded,
                            status.scroller_touched,
                            status.keys_touched,
                            status.position};

    assign tx_frame = (pending_cmd_q == CMD_NORMAL) ? normal_report : alt_report;

    tne_spi_slave u_spi (
        .clk        (clk),
        .rst_n      (rst_n),
        .sclk_s     (pin_s2_q[1]),
        .ss_n_s     (pin_s2_q[0]),
        .mosi_s     (pin_s2_q[2]),
        .tx_frame   (tx_frame),
        .miso_q     (spi_miso),
        .miso_oe_q  (spi_miso_oe),
        .frame_ok_q (frame_ok),
        .rx_q       (rx_word)
    );

    ////////////////////////////////////////////////////////////////////////
    // command tracking
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pending_cmd_q <= CMD_NORMAL;
        end else if (frame_ok) begin
            pending_cmd_q <= rx_cmd;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_valid_q <= 1'b0;
            cmd_word_q  <= '0;
        end else begin
            cmd_valid_q <= frame_ok && rx_cmd != CMD_NORMAL;
            if (frame_ok && rx_cmd != CMD_NORMAL) begin
                cmd_word_q <= rx_word;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // settings, applied only once a whole frame is in
    logic normal_ok;

    assign normal_ok = frame_ok && rx_cmd == CMD_NORMAL;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= CFG_RESET;
        end else if (normal_ok) begin
            cfg_q.key_grouping_suppression <= rx_word[GRP_HI:GRP_LO];
            cfg_q.scroller_type_select     <= rx_word[SCRL_BIT];
            // stored for old drivers, read by nothing
            cfg_q.proximity_compat_bit     <= rx_word[COMPAT_BIT];
            cfg_q.burst_after_wake         <= rx_word[BAW_BIT];
            cfg_q.detect_integrator        <= rx_word[INTEG_BIT];
            cfg_q.max_on_duration          <= rx_word[ONDUR_HI:ONDUR_LO];
            if (rx_word[SLP_HI:SLP_LO] != SLP_RSVD) begin
                cfg_q.sleep_interval_select <= rx_word[SLP_HI:SLP_LO];
            end
            if (rx_word[RES_HI:RES_LO] != RES_RSVD) begin
                cfg_q.resolution <= rx_word[RES_HI:RES_LO];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            confirm_count_q <= INTEG_LONG;
        end else begin
            confirm_count_q <= cfg_q.detect_integrator ? INTEG_LONG : INTEG_SHORT;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // recalibration requests, one pulse per frame that carries them
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            key_recal_q        <= 1'b0;
            key_recal_target_q <= 3'h0;
            scroller_recal_q   <= 1'b0;
        end else begin
            key_recal_q      <= normal_ok && rx_word[KRECAL_BIT];
            scroller_recal_q <= normal_ok && rx_word[SRECAL_BIT];
            if (normal_ok) begin
                key_recal_target_q <= rx_word[KEY_HI:KEY_LO];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // position width latched at the start of each scroller touch
    logic touched_d_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            touched_d_q  <= 1'b0;
            res_active_q <= CFG_RESET.resolution;
        end else begin
            touched_d_q <= status.scroller_touched;
            if (status.scroller_touched && !touched_d_q) begin
                res_active_q <= cfg_q.resolution;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // millisecond prescaler and interval timers
    logic [15:0]       pre_q;
    logic              ms_tick_q;
    logic              lp_periodic;
    logic              sync_mode;
    logic              sleep_mode;
    logic              sleep_run;
    logic [TIME_W-1:0] sleep_limit;
    logic              sleep_tick;
    logic              any_touch;
    logic              ondur_run;
    logic [TIME_W-1:0] ondur_limit;
    logic              ondur_done;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_q     <= '0;
            ms_tick_q <= 1'b0;
        end else if (pre_q == 16'(CYC_PER_MS_P - 1)) begin
            pre_q     <= '0;
            ms_tick_q <= 1'b1;
        end else begin
            pre_q     <= pre_q + 16'h0001;
            ms_tick_q <= 1'b0;
        end
    end

    assign lp_periodic = cfg_q.sleep_interval_select != SLP_FREE &&
                         cfg_q.sleep_interval_select <= SLP_480;
    assign sync_mode   = cfg_q.sleep_interval_select == SLP_SYNC;
    assign sleep_mode  = cfg_q.sleep_interval_select == SLP_SLEEP;
    assign sleep_run   = lp_periodic | sync_mode;

    always_comb begin
        unique case (cfg_q.sleep_interval_select)
            3'h1:    sleep_limit = SLEEP1_MS;
            3'h2:    sleep_limit = SLEEP2_MS;
            3'h3:    sleep_limit = SLEEP3_MS;
            default: sleep_limit = SLEEP4_MS;
        endcase
    end

    tne_ms_timer u_sleep_tmr (
        .clk     (clk),
        .rst_n   (rst_n),
        .ms_tick (ms_tick_q),
        .run     (sleep_run),
        .limit   (sleep_limit),
        .done_q  (sleep_tick)
    );

    assign any_touch = status.scroller_touched | (|status.keys_touched);
    assign ondur_run = any_touch && cfg_q.max_on_duration != ONDUR_OFF;

    always_comb begin
        unique case (cfg_q.max_on_duration)
            2'h0:    ondur_limit = ONDUR0_MS;
            2'h1:    ondur_limit = ONDUR1_MS;
            default: ondur_limit = ONDUR2_MS;
        endcase
    end

    tne_ms_timer u_ondur_tmr (
        .clk     (clk),
        .rst_n   (rst_n),
        .ms_tick (ms_tick_q),
        .run     (ondur_run),
        .limit   (ondur_limit),
        .done_q  (ondur_done)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ondur_recal_all_q <= 1'b0;
        end else begin
            ondur_recal_all_q <= ondur_done;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // acquisition burst scheduling, decided on the settings in force
    logic wake_burst;
    logic tick_burst;
    logic free_burst;

    assign wake_burst = ss_rise && (sync_mode || sleep_mode ||
                                    (lp_periodic && cfg_q.burst_after_wake));
    assign tick_burst = sleep_tick && sleep_run;
    assign free_burst = cfg_q.sleep_interval_select == SLP_FREE && !acq_busy && !burst_req_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            burst_req_q <= 1'b0;
        end else begin
            burst_req_q <= wake_burst | tick_burst | free_burst;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    cmd_defer_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        frame_ok && rx_cmd != CMD_NORMAL |=> pending_cmd_q == $past(rx_cmd))
    else $error("deferred command not recorded");

    grp_apply_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        normal_ok |=> cfg_q.key_grouping_suppression == rx_word[GRP_HI:GRP_LO])
    else $error("grouping not applied after full frame");

    no_partial_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        !frame_ok |=> $stable(cfg_q))
    else $error("settings changed without a complete frame");

    wake_off_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        ss_rise && lp_periodic && !cfg_q.burst_after_wake && !sleep_tick |=> !burst_req_q)
    else $error("extra burst with wake burst disabled");

    wake_on_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        ss_rise && (sync_mode || sleep_mode) |=> burst_req_q)
    else $error("no burst after select rise in sync or sleep");

    sleep_only_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        sleep_mode && !ss_rise |=> !burst_req_q)
    else $error("burst in sleep code without select rise");

    res_hold_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        touched_d_q && status.scroller_touched |=> $stable(res_active_q))
    else $error("resolution changed during a touch");

    recal_key_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        normal_ok && rx_word[KRECAL_BIT] |=> key_recal_q ##1 !key_recal_q)
    else $error("key recal request not a single pulse");

    report_mux_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        pending_cmd_q == CMD_NORMAL |-> tx_frame[15:8] ==
            {status.scroller_touched, status.keys_touched})
    else $error("normal report key byte wrong");

endmodule

// [tne_host_model.sv]
`timescale 1ns/1ps
module tne_host_model (
    input  logic clk,
    input  logic miso,
    output logic sclk,
    output logic ss_n,
    output logic mosi
);
    initial begin
        sclk = 1'b0;
        ss_n = 1'b1;
        mosi = 1'b0;
    end

    task automatic hc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // mode 0 master, 200 ns sclk; zero bits gives a bare select pulse
    task automatic xfer(input logic [23:0] tx, input int nbits, output logic [23:0] rx);
        rx = '0;
        hc(1);
        ss_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            mosi = tx[23-i];
            hc(4);
            sclk = 1'b1;
            hc(4);
            rx = {rx[22:0], miso};
            sclk = 1'b0;
        end
        hc(4);
        ss_n = 1'b1;
        // released data line must not keep the last bit
        mosi = ~mosi;
        hc(8);
    endtask
endmodule

// [tne_decoder_tb_top.sv]
`timescale 1ns/1ps
module tne_decoder_tb_top import tne_pkg::*;;
    logic        clk, rst_n, sclk, ss_n, mosi, miso, oe, busy, burst, krec, srec, mrec, cvld;
    tne_status_s st;
    tne_cfg_s    cfg;
    logic [2:0]  res_act, conf, ktgt, pend, tgt;
    logic [23:0] alt, cword, cseen, rx;
    int          failures, samples_checked, nb, nk, ns, nm, nc, no, b0, k0, s0;

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    tne_host_model host_u (.clk(clk), .miso(miso), .sclk(sclk), .ss_n(ss_n), .mosi(mosi));
    tne_decoder #(.CYC_PER_MS_P(4)) dut_u (.clk(clk), .rst_n(rst_n), .spi_sclk(sclk),
        .spi_ss_n(ss_n), .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(oe), .status(st),
        .acq_busy(busy), .alt_report(alt), .cfg_q(cfg), .res_active_q(res_act),
        .confirm_count_q(conf), .burst_req_q(burst), .key_recal_q(krec),
        .key_recal_target_q(ktgt), .scroller_recal_q(srec), .ondur_recal_all_q(mrec),
        .cmd_valid_q(cvld), .cmd_word_q(cword), .pending_cmd_q(pend));

    always @(posedge clk) begin
        if (burst === 1'b1) nb++;
        if (oe === 1'b1) no++;
        if (srec === 1'b1) ns++;
        if (mrec === 1'b1) nm++;
        if (krec === 1'b1) begin
            nk++;
            tgt <= ktgt;
        end
        if (cvld === 1'b1) begin
            nc++;
            cseen <= cword;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [23:0] rep(input logic lp);
        rep = {st.scroller_calibrating, st.key_calibrating, st.scroller_error, st.key_error,
               lp, 2'b00, st.threshold_loaded, st.scroller_touched, st.keys_touched,
               st.position};
    endfunction

    task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        chk(24'(cfg), 24'(CFG_RESET), "reset cfg");
        chk(24'(pend), 24'h0, "reset pending");
        chk(24'(res_act), 24'h6, "reset res");
        chk(24'(conf), 24'h6, "reset confirm");
        chk(24'(oe), 24'h0, "reset oe");
        busy = 1'b0;
        repeat (20) @(negedge clk);
        busy = 1'b1;
        chk(24'(nb > 4), 24'h1, "free run bursts");
        $display("test reset done");
    endtask

    task automatic t_settings;
        st.keys_touched = 7'h4a;
        b0 = no;
        host_u.xfer(24'h1d4360, 24, rx);
        chk(rx, rep(1'b0), "first report");
        // output enable spans the 196 cycles of select low
        chk(24'(no - b0), 24'hc4, "select window");
        chk(24'(cfg), 24'({3'h5, 1'b1, 1'b1, 3'h3, 1'b0, 1'b0, 2'h2, 3'h3}), "cfg");
        chk(24'(conf), 24'h2, "confirm two");
        host_u.xfer(24'h001ec0, 24, rx);
        chk(rx, rep(1'b1), "lps report");
        st.keys_touched = 7'h00;
        $display("test settings done");
    endtask

    task automatic t_recal;
        for (int k = 0; k < 8; k++) begin
            k0 = nk;
            s0 = ns;
            host_u.xfer({5'h00, 3'((k < 6) ? k : 0), 1'b0, 2'(k), 5'h1e, 5'h1b, 3'(k)}, 24, rx);
            chk(24'(nk - k0), 24'h1, "key recal");
            chk(24'(ns - s0), 24'h1, "scroller recal");
            chk(24'(tgt), 24'(k), "recal target");
            chk(24'(cfg.key_grouping_suppression), 24'((k < 6) ? k : 0), "grouping");
            chk(24'(cfg.max_on_duration), 24'(k % 4), "on-duration");
        end
        k0 = nk;
        host_u.xfer(24'h001ec0, 24, rx);
        chk(24'(nk - k0), 24'h0, "recal cleared");
        $display("test recal done");
    endtask

    task automatic t_cmd;
        b0 = nc;
        host_u.xfer(24'h200000, 24, rx);
        chk(rx, rep(1'b1), "cmd frame report");
        chk(24'(nc - b0), 24'h1, "cmd valid");
        chk(cseen, 24'h200000, "cmd word");
        host_u.xfer(24'h4a7f00, 12, rx);
        chk(24'(pend), 24'h1, "partial pending");
        chk(24'(cfg.sleep_interval_select), 24'h6, "partial cfg");
        host_u.xfer(24'h001ec0, 24, rx);
        chk(rx, alt, "deferred answer");
        host_u.xfer(24'h001ec0, 24, rx);
        chk(rx, rep(1'b1), "normal again");
        $display("test cmd done");
    endtask

    task automatic t_burst;
        logic [7:0] b1[4] = '{8'h1c, 8'h14, 8'h16, 8'h15};
        int         ex[4] = '{1, 0, 1, 1};
        for (int i = 0; i < 4; i++) begin
            host_u.xfer({8'h00, b1[i], 8'hc0}, 24, rx);
            b0 = nb;
            host_u.xfer(24'h0, 0, rx);
            chk(24'(nb - b0), 24'(ex[i]), "wake burst");
        end
        b0 = nb;
        repeat (2000) @(negedge clk);
        chk(24'(nb - b0 >= 1), 24'h1, "heartbeat");
        host_u.xfer(24'h0016c0, 24, rx);
        b0 = nb;
        repeat (2000) @(negedge clk);
        chk(24'(nb - b0), 24'h0, "sleep quiet");
        host_u.xfer(24'h0017c0, 24, rx);
        chk(24'(cfg.sleep_interval_select), 24'h6, "reserved sleep");
        // 60 ms and 120 ms codes, wake burst off: 4 and 2 bursts in 250 ms
        for (int c = 1; c < 3; c++) begin
            host_u.xfer({8'h00, 5'h02, 3'(c), 8'hc0}, 24, rx);
            b0 = nb;
            repeat (1000) @(negedge clk);
            chk(24'(nb - b0), 24'(4 / c), "lp period");
        end
        $display("test burst done");
    endtask

    task automatic t_res_mod;
        host_u.xfer(24'h001e40, 24, rx);
        chk(24'(res_act), 24'h6, "res held");
        host_u.xfer(24'h001e00, 24, rx);
        chk(24'(cfg.resolution), 24'h2, "reserved res");
        st.scroller_touched = 1'b1;
        repeat (4) @(negedge clk);
        chk(24'(res_act), 24'h2, "res on touch");
        st.scroller_touched = 1'b0;
        st.keys_touched = 7'h01;
        b0 = nm;
        repeat (39900) @(negedge clk);
        chk(24'(nm - b0), 24'h0, "on-duration early");
        repeat (300) @(negedge clk);
        chk(24'(nm - b0), 24'h1, "on-duration expiry");
        st.keys_touched = 7'h00;
        $display("test res mod done");
    endtask

    initial begin
        rst_n = 1'b0;
        busy = 1'b1;
        alt = 24'h5ac3e1;
        st = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 7'h00, 8'h93};
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        t_reset();
        t_settings();
        t_recal();
        t_cmd();
        t_burst();
        t_res_mod();
        results();
    end

    initial begin
        repeat (70000) @(posedge clk);
        failures++;
        $display("[FAIL] %0t watchdog expired", $time);
        results();
    end
endmodule
